// file: hdl/adx_defines.svh
// Constants for the addition execution block
`ifndef ADX_DEFINES_SVH
`define ADX_DEFINES_SVH
`define ADX_OP_LIT_HI 8'h0F
`define ADX_OP_FILE_HI 6'h09
`define ADX_OP_FILEC_HI 6'h08
`define ADX_DEST_POS 9
`define ADX_BANK_POS 8
`define ADX_WORKING_REGISTER_RST 8'h00
`define ADX_FLAGS_RST 5'h00
`define ADX_ACCESS_SPLIT 8'h80
`define ADX_ACCESS_HI_BANK 4'hF
`endif

// file: hdl/adx_pkg.sv
// Types for the addition execution block
package adx_pkg;
  typedef enum logic [1:0] {
    PH_DECODE,
    PH_READ,
    PH_PROCESS,
    PH_WRITE
  } adx_phase_type;
  typedef enum logic [1:0] {
    OP_NONE,
    OP_LIT,
    OP_FILE,
    OP_FILEC
  } adx_op_type;
  typedef struct packed {
    logic neg;
    logic sign_wrap;
    logic zero;
    logic nibble_carry;
    logic carry;
  } adx_flags_type;
  typedef struct packed {
    logic [11:0] addr;
    logic [7:0] data;
  } adx_file_access_type;
  typedef struct packed {
    adx_phase_type phase;
    adx_op_type op;
    logic [15:0] opcode;
    logic [7:0] operand;
    logic [7:0] result;
    adx_flags_type flags;
    logic [7:0] working_register;
    logic busy;
    logic done;
    logic file_rd;
    logic file_we;
    adx_file_access_type file;
  } adx_state_type;
endpackage

// file: hdl/adx_add_exec.sv
// Executes the three 8-bit addition instructions over four clock phases
// Functional notes
// - Literal add: working register plus literal.
// - File add: working register plus file register.
// - Destination bit picks working or file.
// - Bank bit picks access or selected bank.
// - Carry add: working, file and carry.
// - All adds update five status flags.
`timescale 1ns/1ps
`default_nettype none
`include "adx_defines.svh"
module adx_add_exec (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Instruction issue
  input wire logic issue_i,
  input wire logic [15:0] opcode_i,
  output logic ready_o,
  output logic done_o,
  output logic unsupported_o,
  // Bank selection
  input wire logic [3:0] bank_select_register_i,
  // Data memory
  output logic file_rd_o,
  output logic file_we_o,
  output adx_pkg::adx_file_access_type file_o,
  input wire logic [7:0] file_rdata_i,
  // Architectural state
  output logic [7:0] working_register_o,
  output adx_pkg::adx_flags_type flags_o
);
  import adx_pkg::*;

  adx_state_type st;
  adx_state_type next_st;
  logic [8:0] sum;
  logic [4:0] low_sum;
  logic carry_in;

  function automatic adx_op_type decode_op(input logic [15:0] op);
    if (op[15:8] == `ADX_OP_LIT_HI)
      decode_op = OP_LIT;
    else if (op[15:10] == `ADX_OP_FILE_HI)
      decode_op = OP_FILE;
    else if (op[15:10] == `ADX_OP_FILEC_HI)
      decode_op = OP_FILEC;
    else
      decode_op = OP_NONE;
  endfunction

  // Access bank maps low half to bank 0, high half to the top bank
  function automatic logic [11:0] form_addr(input logic [15:0] op, input logic [3:0] bank);
    if (op[`ADX_BANK_POS])
      form_addr = {bank, op[7:0]};
    else if (op[7:0] < `ADX_ACCESS_SPLIT)
      form_addr = {4'h0, op[7:0]};
    else
      form_addr = {`ADX_ACCESS_HI_BANK, op[7:0]};
  endfunction

  ////////////////////////////////////////////////////////////////////////
  assign carry_in = (st.op == OP_FILEC) ? st.flags.carry : 1'b0;
  assign sum = {1'b0, st.working_register} + {1'b0, st.operand} + {8'h00, carry_in};
  assign low_sum = {1'b0, st.working_register[3:0]} + {1'b0, st.operand[3:0]} + {4'h0, carry_in};

  always_comb begin
    next_st = st;
    next_st.done = 1'b0;
    next_st.file_we = 1'b0;
    next_st.file_rd = 1'b0;
    case (st.phase)
      PH_DECODE: begin
        if (issue_i && st.busy == 1'b0) begin
          next_st.opcode = opcode_i;
          next_st.op = decode_op(opcode_i);
          next_st.file.addr = form_addr(opcode_i, bank_select_register_i);
          next_st.file_rd = (decode_op(opcode_i) == OP_FILE) || (decode_op(opcode_i) == OP_FILEC);
          next_st.busy = 1'b1;
          next_st.phase = PH_READ;
        end
      end
      PH_READ: begin
        // Literal comes from the word itself, no memory access needed
        next_st.operand = (st.op == OP_LIT) ? st.opcode[7:0] : file_rdata_i;
        next_st.phase = PH_PROCESS;
      end
      PH_PROCESS: begin
        next_st.result = sum[7:0];
        next_st.flags.carry = sum[8];
        next_st.flags.nibble_carry = low_sum[4];
        next_st.flags.zero = (sum[7:0] == 8'h00);
        next_st.flags.neg = sum[7];
        next_st.flags.sign_wrap = (st.working_register[7] == st.operand[7])
          && (sum[7] != st.working_register[7]);
        next_st.phase = PH_WRITE;
      end
      PH_WRITE: begin
        // Flags only move for decoded additions; others pass untouched
        if (st.op == OP_NONE) begin
          next_st.flags = flags_o;
        end else if (st.op == OP_LIT || st.opcode[`ADX_DEST_POS] == 1'b0) begin
          next_st.working_register = st.result;
        end else begin
          next_st.file.data = st.result;
          next_st.file_we = 1'b1;
        end
        next_st.done = 1'b1;
        next_st.busy = 1'b0;
        next_st.phase = PH_DECODE;
      end
      default: begin
        next_st.phase = PH_DECODE;
      end
    endcase
  end

  // Committed flags are kept apart so an unsupported word leaves them alone
  adx_flags_type flags_q;
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      flags_q <= `ADX_FLAGS_RST;
    end else if (st.phase == PH_WRITE && st.op != OP_NONE) begin
      flags_q <= st.flags;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      st <= '0;
      st.phase <= PH_DECODE;
      st.op <= OP_NONE;
      st.working_register <= `ADX_WORKING_REGISTER_RST;
    end else begin
      st <= next_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  assign flags_o = flags_q;
  assign ready_o = (st.phase == PH_DECODE);
  assign done_o = st.done;
  assign unsupported_o = st.done && (st.op == OP_NONE);
  assign file_rd_o = st.file_rd;
  assign file_we_o = st.file_we;
  assign file_o = st.file;
  assign working_register_o = st.working_register;
endmodule // adx_add_exec
`default_nettype wire

// file: sim/adx_props.sv
// Port checker for adx_add_exec
`timescale 1ns/1ps
`default_nettype none
module adx_props (
  input wire logic clk_i, rst_i, issue_i, ready_o, done_o, file_rd_o, file_we_o,
  input wire logic [15:0] opcode_i,
  input wire logic [3:0] bank_select_register_i,
  input wire logic [7:0] working_register_o,
  input wire adx_pkg::adx_file_access_type file_o,
  input wire adx_pkg::adx_flags_type flags_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  wire tk = issue_i && ready_o;
  wire fo = tk && opcode_i[15:11] == 5'h04;
  done_four_a: assert property (tk |-> ##4 done_o) else $error("late");
  ready_gap_a: assert property (tk |=> !ready_o [*3] ##1 ready_o) else $error("gap");
  read_file_a: assert property (fo |=> file_rd_o) else $error("read");
  lit_sum_a: assert property (tk && opcode_i[15:8] == 8'h0f |-> ##4
    working_register_o == $past(working_register_o, 4) + $past(opcode_i[7:0], 4))
    else $error("sum");
  bank_addr_a: assert property (fo |=> file_o.addr == {$past(opcode_i[8]) ?
    $past(bank_select_register_i) : {4{$past(opcode_i[7])}}, $past(opcode_i[7:0])})
    else $error("addr");
  dest_write_a: assert property (fo |-> ##4 file_we_o == $past(opcode_i[9], 4))
    else $error("dest");
  flag_hold_a: assert property (!done_o |-> $stable(flags_o))
    else $error("flags");
endmodule // adx_props
bind adx_add_exec adx_props i_props (.*);
`default_nettype wire

// file: sim/adx_file_model.sv
// Data memory model
`timescale 1ns/1ps
`default_nettype none
module adx_file_model (
  input wire logic clk_i, rd_i, we_i,
  input wire adx_pkg::adx_file_access_type f_i,
  output logic [7:0] rdata_o
);
  logic [7:0] mem [4096];
  logic [7:0] last = 8'h00;
  initial foreach (mem[i]) mem[i] = 8'(i);
  // Data stands while the read strobe does; the block samples it then
  assign rdata_o = rd_i ? mem[f_i.addr] : ~last;
  always @(posedge clk_i) begin
    last <= rdata_o; // Idle data is the complement of the last value, so it toggles every cycle
    if (we_i) mem[f_i.addr] <= f_i.data;
  end
endmodule // adx_file_model
`default_nettype wire

// file: sim/test_add_instruction_execution.sv
// Bench for adx_add_exec
`timescale 1ns/1ps
`default_nettype none
module test_add_instruction_execution;
  import adx_pkg::*;
  logic clk_i = 0, rst_i = 1, issue_i = 0, ready_o, done_o, unsupported_o, file_rd_o;
  logic file_we_o;
  logic [15:0] opcode_i = 0;
  logic [3:0] bank_select_register_i = 0;
  logic [7:0] file_rdata_i, working_register_o;
  adx_file_access_type file_o;
  adx_flags_type flags_o;
  int failures = 0, checks = 0;
  adx_add_exec i_dut (.*);
  adx_file_model i_mem (.clk_i, .rd_i(file_rd_o), .we_i(file_we_o), .f_i(file_o),
    .rdata_o(file_rdata_i));
  task automatic eq(input logic [7:0] g, e);
    checks++;
    if (g !== e) begin
      failures++;
      $display("[ERR] %0t %h %h", $time, g, e);
    end
  endtask
  task automatic report_and_stop;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic run(input logic [15:0] op, input logic [3:0] b, input logic [7:0] r,
    input logic [4:0] f);
    @(posedge clk_i);
    issue_i <= 1;
    opcode_i <= op;
    bank_select_register_i <= b;
    repeat (4) @(posedge clk_i) issue_i <= 0;
    #1;
    eq(done_o, 1);
    eq(unsupported_o, !(op[15:8] == 8'h0f || op[15:11] == 5'h04));
    eq(file_we_o, op[15:11] == 5'h04 && op[9]);
    eq(file_we_o ? file_o.data : working_register_o, r);
    @(posedge clk_i) #1 eq(flags_o, f);
  endtask
  task automatic t_lit;
    run(16'h0feb, 0, 8'heb, 5'h10);
    run(16'h0f15, 0, 8'h00, 5'h07);
    $display("lit test end");
  endtask
  task automatic t_file;
    run(16'h2310, 2, 8'h11, 5'h00);
    run(16'h2690, 9, 8'h90, 5'h10);
    run(16'h25c2, 3, 8'hc2, 5'h10);
    run(16'h0f80, 0, 8'h42, 5'h09);
    $display("file test end");
  endtask
  task automatic t_bad;
    run(16'h0b12, 0, 8'h42, 5'h09);
    $display("other test end");
  endtask
  initial begin
    forever #2 clk_i = ~clk_i;
  end
  initial begin
    repeat (20) @(posedge clk_i);
    rst_i <= 0;
    t_lit;
    t_file;
    t_bad;
    report_and_stop;
  end
  initial begin
    #1000;
    failures++;
    report_and_stop;
  end
endmodule // test_add_instruction_execution
`default_nettype wire
